// >>> hims_pkg.sv
// constants for the processor interrupt mask, event status and part identifier block
// assumes command codes arrive over the parallel processor port, one code per access
package hims_pkg;

  // command codes: read codes have bit 7 low, write codes have bit 7 high
  localparam logic [7:0] CODE_STATUS_RD = 8'h24;
  localparam logic [7:0] CODE_STATUS_WR = 8'ha4;
  localparam logic [7:0] CODE_MASK_RD = 8'h25;
  localparam logic [7:0] CODE_MASK_WR = 8'ha5;
  localparam logic [7:0] CODE_PART_ID_RD = 8'h27;

  // register widths and reset values
  localparam int REG_W = 16;
  localparam int EVT_W = 7;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [6:0] STATUS_RESET = 7'h00;

  // field positions shared by status and mask
  localparam int BIT_SOF = 0;
  localparam int BIT_ASYNC_LIST = 1;
  localparam int BIT_XFER_END = 2;
  localparam int BIT_OPER_UPDATE = 4;
  localparam int BIT_SUSPEND_DONE = 5;
  localparam int BIT_CLOCK_READY = 6;

  // implemented bits: 6..4 and 2..0, bit 3 and 15..7 reserved
  localparam logic [6:0] IMPL_BITS = 7'h77;

  // suspend sequence, gray coded along run -> wait -> suspended
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SUSP_WAIT = 2'b01,
    ST_SUSPENDED = 2'b11
  } hims_state_t;

endpackage : hims_pkg

// >>> hims_event_latch.sv
// sticky event flags with write-one-to-clear
// assumes set and clear pulses are synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none

module hims_event_latch #(
  parameter int W = 7,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // set and clear
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  // held flags
  output logic [W-1:0] o_flags
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    flags_d = (flags_q & ~i_clr) | i_set;
  end

  // flag storage
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      flags_q <= RESET_VAL;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

endmodule : hims_event_latch

`default_nettype wire

// >>> hims_top.sv
// interrupt mask, event status, suspend sequence and part identifier
// assumes one command access per cycle strobe, read data returned one cycle later
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE_01] mask bit 6 lets clock-ready event drive the interrupt, zero blocks it
// [RULE_02] mask bit 5 lets the host-suspended event drive the interrupt
// [RULE_03] suspend request waits for downstream suspend, then stops frame starts
// [RULE_04] mask bit 4 enables the operational-register update interrupt
// [RULE_05] mask bit 2 enables the end-of-transfer interrupt
// [RULE_06] mask bit 1 enables the async list buffer interrupt
// [RULE_07] mask bit 0 enables the start-of-frame interrupt
// [RULE_08] whole mask resets to zero; bits 15..7 and 3 are reserved
// [RULE_09] read-only 16-bit part identifier returned on read code 27h
// [RULE_10] identifier upper byte is product, lower byte is silicon revision
// [RULE_11] interrupt needs pending event, its enable, and global enable together
// [RULE_12] status stays set after reads, cleared only by writing ones
// [RULE_13] reserved mask bits ignore writes, read zero; identifier writes ignored
module hims_top #(
  parameter logic [7:0] PRODUCT_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01  // arbitrary value
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // processor command port
  input wire logic i_acc_valid,
  input wire logic [7:0] i_acc_code,
  input wire logic [hims_pkg::REG_W-1:0] i_acc_wdata,
  output logic [hims_pkg::REG_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // global interrupt enable from the hardware configuration register
  input wire logic i_global_int_enable,
  // host-side event pulses
  input wire logic i_evt_clock_ready,
  input wire logic i_evt_oper_update,
  input wire logic i_evt_xfer_end,
  input wire logic i_evt_async_list,
  input wire logic i_evt_frame_start,
  // suspend control from the host control register and the ports
  input wire logic i_suspend_req,
  input wire logic i_resume_req,
  input wire logic i_downstream_suspended,
  // outputs
  output logic o_int,
  output logic o_sof_run,
  output logic o_suspended
);
  import hims_pkg::*;

  // decoded access of one code
  function automatic logic hit(input logic v, input logic [7:0] c, input logic [7:0] want);
    hit = v && (c == want);
  endfunction : hit

  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic int_q;
  logic int_d;
  hims_state_t state_q;
  hims_state_t state_d;
  logic sof_run_q;
  logic sof_run_d;
  logic suspended_q;
  logic suspended_d;
  logic susp_evt;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [EVT_W-1:0] status;
  logic [15:0] part_id;

  // product in the high byte, revision in the low byte
  assign part_id = {PRODUCT_CODE, REVISION_CODE};  // [RULE_10]

  // suspend sequence; frame starts continue until downstream is asleep
  always_comb
  begin
    state_d = state_q;
    susp_evt = 1'b0;
    unique case (state_q)
      ST_RUN:
      begin
        if (i_suspend_req)
        begin
          state_d = ST_SUSP_WAIT;  // [RULE_03]
        end
      end
      ST_SUSP_WAIT:
      begin
        if (i_downstream_suspended)
        begin
          state_d = ST_SUSPENDED;  // [RULE_03]
          susp_evt = 1'b1;
        end
      end
      ST_SUSPENDED:
      begin
        if (i_resume_req)
        begin
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_RUN;  // unused code recovers to run
      end
    endcase
    sof_run_d = (state_d != ST_SUSPENDED);
    suspended_d = (state_d == ST_SUSPENDED);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= ST_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // event sources; frame-start events are dropped once suspended
  always_comb
  begin
    evt_set = '0;
    evt_set[BIT_SOF] = i_evt_frame_start && (state_q != ST_SUSPENDED);
    evt_set[BIT_ASYNC_LIST] = i_evt_async_list;
    evt_set[BIT_XFER_END] = i_evt_xfer_end;
    evt_set[BIT_OPER_UPDATE] = i_evt_oper_update;
    evt_set[BIT_SUSPEND_DONE] = susp_evt;
    evt_set[BIT_CLOCK_READY] = i_evt_clock_ready;
    // only a write of ones clears; reads leave flags alone
    evt_clr = hit(i_acc_valid, i_acc_code, CODE_STATUS_WR) ? (i_acc_wdata[EVT_W-1:0] & IMPL_BITS) : '0;  // [RULE_12]
  end

  hims_event_latch #(
    .W(EVT_W),
    .RESET_VAL(STATUS_RESET)
  ) u_status (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_set(evt_set),
    .i_clr(evt_clr),
    .o_flags(status)
  );

  // mask write keeps reserved bits at zero
  always_comb
  begin
    mask_d = mask_q;
    if (hit(i_acc_valid, i_acc_code, CODE_MASK_WR))
    begin
      mask_d = {9'h000, i_acc_wdata[EVT_W-1:0] & IMPL_BITS};  // [RULE_13]
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mask_q <= MASK_RESET;  // [RULE_08]
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // interrupt: each enable gates its own flag, global enable gates all
  always_comb
  begin
    int_d = 1'b0;
    if (i_global_int_enable)  // [RULE_11]
    begin
      int_d = (status[BIT_CLOCK_READY] & mask_q[BIT_CLOCK_READY])  // [RULE_01]
        | (status[BIT_SUSPEND_DONE] & mask_q[BIT_SUSPEND_DONE])  // [RULE_02]
        | (status[BIT_OPER_UPDATE] & mask_q[BIT_OPER_UPDATE])  // [RULE_04]
        | (status[BIT_XFER_END] & mask_q[BIT_XFER_END])  // [RULE_05]
        | (status[BIT_ASYNC_LIST] & mask_q[BIT_ASYNC_LIST])  // [RULE_06]
        | (status[BIT_SOF] & mask_q[BIT_SOF]);  // [RULE_07]
    end
  end

  // read path; unknown read codes answer zero; the identifier write code and other write codes get no read valid
  always_comb
  begin
    rd_valid_d = i_acc_valid && !i_acc_code[7];
    rd_data_d = 16'h0000;
    if (hit(i_acc_valid, i_acc_code, CODE_STATUS_RD))
    begin
      rd_data_d = {9'h000, status};
    end
    else if (hit(i_acc_valid, i_acc_code, CODE_MASK_RD))
    begin
      rd_data_d = mask_q;
    end
    else if (hit(i_acc_valid, i_acc_code, CODE_PART_ID_RD))
    begin
      rd_data_d = part_id;  // [RULE_09]
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      int_q <= 1'b0;
      sof_run_q <= 1'b1;
      suspended_q <= 1'b0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      int_q <= int_d;
      sof_run_q <= sof_run_d;  // [RULE_03]
      suspended_q <= suspended_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_int = int_q;
  assign o_sof_run = sof_run_q;
  assign o_suspended = suspended_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_suspend_asked;
    (state_q == ST_RUN) && i_suspend_req;
  endsequence

  sequence s_downstream_asleep;
    (state_q == ST_SUSP_WAIT) && i_downstream_suspended;
  endsequence

  AST_CLKRDY_MASKED: assert property ( // [RULE_01]
    (status == 7'h40 && !mask_q[BIT_CLOCK_READY]) |=> !o_int)
    else $error("clock-ready raised interrupt while masked");

  AST_SUSPEND_INT: assert property ( // [RULE_02]
    s_downstream_asleep ##1 (mask_q[BIT_SUSPEND_DONE] && i_global_int_enable) |=> o_int)
    else $error("suspend event did not raise interrupt");

  AST_SUSPEND_SEQ: assert property ( // [RULE_03]
    s_suspend_asked ##1 !i_downstream_suspended |=> o_sof_run && !o_suspended)
    else $error("stopped frames before downstream suspended");

  AST_SUSPEND_STOP: assert property ( // [RULE_03]
    s_downstream_asleep |=> !o_sof_run && o_suspended && status[BIT_SUSPEND_DONE])
    else $error("suspend entry not completed");

  AST_EVENT_TO_INT: assert property ( // [RULE_05]
    (i_evt_xfer_end && mask_q[BIT_XFER_END] && i_global_int_enable)
      ##1 (i_global_int_enable && mask_q[BIT_XFER_END]) |=> o_int)
    else $error("enabled transfer-end event missed interrupt");

  AST_MASK_WRITE: assert property ( // [RULE_13]
    hit(i_acc_valid, i_acc_code, CODE_MASK_WR) |=> mask_q == {9'h000, $past(i_acc_wdata[6:0]) & 7'h77})
    else $error("mask write stored wrong value");

  AST_MASK_RESERVED: assert property ( // [RULE_08]
    mask_q[15:7] == 9'h000 && !mask_q[3])
    else $error("reserved mask bit set");

  AST_PART_ID: assert property ( // [RULE_09]
    hit(i_acc_valid, i_acc_code, CODE_PART_ID_RD) |=> o_rd_valid && o_rd_data == {PRODUCT_CODE, REVISION_CODE})
    else $error("identifier read returned wrong value");

  AST_GLOBAL_GATE: assert property ( // [RULE_11]
    !i_global_int_enable |=> !o_int)
    else $error("interrupt without global enable");

  AST_STICKY_READ: assert property ( // [RULE_12]
    (status[BIT_ASYNC_LIST] && hit(i_acc_valid, i_acc_code, CODE_STATUS_RD))
      ##1 !hit(i_acc_valid, i_acc_code, CODE_STATUS_WR) |-> status[BIT_ASYNC_LIST][*2])
    else $error("status flag lost on read");

  AST_W1C: assert property ( // [RULE_12]
    (hit(i_acc_valid, i_acc_code, CODE_STATUS_WR) && i_acc_wdata[BIT_SOF] && !evt_set[BIT_SOF]) |=> !status[BIT_SOF])
    else $error("write of one did not clear flag");

endmodule : hims_top

`default_nettype wire

// >>> hims_cpu_model.sv
// far-side model: host-side event pulses and the downstream suspend level
// assumes the bench calls fire() at a falling edge and pulses suspend/resume
`timescale 1ns/1ps
`default_nettype none

module hims_cpu_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // suspend control as seen by the ports
  input wire logic i_suspend_req,
  input wire logic i_resume_req,
  // event pulses and downstream level
  output logic [4:0] o_evt,
  output logic o_downstream_suspended
);
  int cnt;

  initial o_evt = 5'h00;

  // one-cycle pulse, launched and dropped off the sampling edge
  task automatic fire(input int k);
    o_evt[k] = 1'b1;
    @(negedge i_clk);
    o_evt[k] = 1'b0;
  endtask : fire

  // downstream devices settle some cycles after the suspend write, never at once
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 0;
      o_downstream_suspended <= 1'b0;
    end
    else if (i_resume_req)
    begin
      cnt <= 0;
      o_downstream_suspended <= 1'b0;
    end
    else if (i_suspend_req || cnt > 0)
    begin
      cnt <= (cnt == DLY) ? 0 : cnt + 1;
      o_downstream_suspended <= (cnt == DLY);
    end
  end
endmodule : hims_cpu_model

`default_nettype wire

// >>> testbench.sv
// self-checking bench for the interrupt mask, status and part identifier
// assumes hims_top and hims_cpu_model; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import hims_pkg::*;
  localparam logic [15:0] ID = 16'h3c02;
  logic clk = 1'b0, rstn = 1'b0, acc_valid = 1'b0, gie = 1'b1, susp_req = 1'b0, res_req = 1'b0;
  logic [7:0] acc_code = 8'h00;
  logic [15:0] acc_wdata = 16'h0000;
  logic [15:0] rd_data;
  logic rd_valid, irq, sof_run, suspended, down;
  logic [4:0] evt;
  int errors = 0, checks = 0, cyc = 0;

  always #5 clk = ~clk;

  hims_top #(.PRODUCT_CODE(ID[15:8]), .REVISION_CODE(ID[7:0])) i_hims_top (.i_clk(clk), .i_rstn(rstn),
    .i_acc_valid(acc_valid), .i_acc_code(acc_code), .i_acc_wdata(acc_wdata), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_global_int_enable(gie), .i_evt_clock_ready(evt[4]), .i_evt_oper_update(evt[3]),
    .i_evt_xfer_end(evt[2]), .i_evt_async_list(evt[1]), .i_evt_frame_start(evt[0]), .i_suspend_req(susp_req),
    .i_resume_req(res_req), .i_downstream_suspended(down), .o_int(irq), .o_sof_run(sof_run),
    .o_suspended(suspended));

  hims_cpu_model i_hims_cpu_model (.i_clk(clk), .i_rstn(rstn), .i_suspend_req(susp_req),
    .i_resume_req(res_req), .o_evt(evt), .o_downstream_suspended(down));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkb(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chkb

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // one access strobe, entered and left at a falling edge; a quiet cycle first
  // so back-to-back calls never lower and raise the strobe in one time step
  task automatic acc(input logic [7:0] code, input logic [15:0] wd);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_code = code;
    acc_wdata = wd;
    @(negedge clk);
    acc_valid = 1'b0;
  endtask : acc

  // answer stands one cycle, so it is judged right after the strobe drops
  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input string what);
    acc(code, 16'h0000);
    chkb({what, " valid"}, 1'b1, rd_valid);
    chk(what, exp, rd_data);
  endtask : rd

  task automatic t_regs;
    chkb("int at reset", 1'b0, irq);
    rd(CODE_MASK_RD, 16'h0000, "mask reset");
    rd(CODE_STATUS_RD, 16'h0000, "status reset");
    rd(CODE_PART_ID_RD, ID, "part id");
    acc(CODE_MASK_WR, 16'hffff);
    rd(CODE_MASK_RD, 16'h0077, "mask reserved");
    acc(8'ha7, 16'h1234);
    rd(CODE_PART_ID_RD, ID, "id after write");
    acc(CODE_MASK_WR, 16'h0000);
  endtask : t_regs

  // event with mask off, then on, then global enable off, then cleared
  task automatic evt_case(input int b, input int k);
    i_hims_cpu_model.fire(k);
    idle(2);
    chkb("int masked", 1'b0, irq);
    rd(CODE_STATUS_RD, 16'h1 << b, "status");
    rd(CODE_STATUS_RD, 16'h1 << b, "status sticky");
    acc(CODE_MASK_WR, 16'h1 << b);
    rd(CODE_MASK_RD, 16'h1 << b, "mask");
    idle(1);
    chkb("int enabled", 1'b1, irq);
    gie = 1'b0;
    idle(2);
    chkb("int global off", 1'b0, irq);
    gie = 1'b1;
    acc(CODE_STATUS_WR, 16'h1 << b);
    idle(2);
    chkb("int cleared", 1'b0, irq);
    rd(CODE_STATUS_RD, 16'h0000, "status cleared");
    // event while already enabled: interrupt two cycles after the pulse
    i_hims_cpu_model.fire(k);
    idle(1);
    chkb("int direct", 1'b1, irq);
    acc(CODE_STATUS_WR, 16'h1 << b);
    idle(2);
    chkb("int direct cleared", 1'b0, irq);
    acc(CODE_MASK_WR, 16'h0000);
  endtask : evt_case

  task automatic t_suspend;
    int n;
    n = 0;
    acc(CODE_MASK_WR, 16'h0021);
    susp_req = 1'b1;
    @(negedge clk);
    susp_req = 1'b0;
    while (suspended !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chkb("suspended", 1'b1, suspended);
    chkb("frames stopped", 1'b0, sof_run);
    idle(2);
    chkb("int suspend", 1'b1, irq);
    i_hims_cpu_model.fire(0);
    idle(2);
    rd(CODE_STATUS_RD, 16'h0020, "status suspended");
    acc(CODE_STATUS_WR, 16'h00ff);
    res_req = 1'b1;
    @(negedge clk);
    res_req = 1'b0;
    idle(2);
    chkb("frames resumed", 1'b1, sof_run);
    chkb("int after clear", 1'b0, irq);
    acc(CODE_MASK_WR, 16'h0000);
  endtask : t_suspend

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    idle(16);
    rstn = 1'b1;
    idle(1);
    t_regs();
    evt_case(0, 0);
    evt_case(1, 1);
    evt_case(2, 2);
    evt_case(4, 3);
    evt_case(6, 4);
    t_suspend();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
